/* rtl/sdram_addr_defs.svh */
// Constants for the SDRAM address, bank and mask decode block
`ifndef SDRAM_ADDR_DEFS_SVH
`define SDRAM_ADDR_DEFS_SVH
`define ADDR_WIDTH 12
`define BANK_COUNT 4
`define SCOPE_BIT 10
`define COL_MSB_X4 9
`define COL_MSB_X8 8
`define COL_MSB_X16 7
`define MASK_LATENCY 2
`define ORG_X4 2'h0
`define ORG_X8 2'h1
`define ORG_X16 2'h2
`define FIFO_DEPTH 4
`endif

/* rtl/sdram_addr_pkg.sv */
// Types for the SDRAM address, bank and mask decode block
package sdram_addr_pkg;
   typedef enum logic [5:0] {
      CMD_NONE = 6'h01,
      CMD_ACTIVATE = 6'h02,
      CMD_READ = 6'h04,
      CMD_WRITE = 6'h08,
      CMD_PRECHARGE = 6'h10,
      CMD_MODE = 6'h20
   } cmd_t;
   typedef struct packed {
      logic [1:0] bank;
      logic [11:0] row;
   } row_sel_t;
   typedef struct packed {
      logic write;
      logic autoPrecharge;
      logic [1:0] bank;
      logic [9:0] column;
   } col_sel_t;
   typedef struct packed {
      logic [15:0] data;
      logic [1:0] laneEnable;
   } wr_beat_t;
endpackage

/* rtl/beat_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module beat_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign inReady = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];

   always_comb begin
      push = inValid && inReady;
      pop = outValid && outReady;
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      if (push) begin
         next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
      end
      if (pop) begin
         next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
      end
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule
`default_nettype wire

/* rtl/sdram_address_mask_decode.sv */
// Address, bank select and byte mask decode for a four-bank SDRAM
// Function
// - Masked write lane leaves memory unchanged
// - Read mask floats outputs two clocks later
// - Low mask bits 7:0, high 15:8 in x16; x4 and x8 use the high mask for all bits
// - Bank select picks target of command
// - Activate takes twelve address bits as row
// - Column width depends on organization
// - Precharge scope bit on read/write: auto precharge
// - Precharge all banks when scope bit high
// - Mode load takes address as op-code
// - Every input except the asynchronous reset sampled on rising clock edge
// - Chip select high ignores commands, masks persist
`timescale 1ns/1ns
`default_nettype none
`include "sdram_addr_defs.svh"
module sdram_address_mask_decode #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [1:0] organization,
   input wire logic chipSelectN,
   input wire sdram_addr_pkg::cmd_t command,
   input wire logic [1:0] bankSelect,
   input wire logic [`ADDR_WIDTH-1:0] address,
   input wire logic low_byte_mask,
   input wire logic high_byte_mask,
   input wire logic burstReadBeat,
   input wire logic burstWriteBeat,
   input wire logic [15:0] writeData,
   input wire logic [15:0] readData,
   output sdram_addr_pkg::row_sel_t rowSelect,
   output logic rowValid,
   output sdram_addr_pkg::col_sel_t columnSelect,
   output logic columnValid,
   output logic [`BANK_COUNT-1:0] prechargeBanks,
   output logic [`ADDR_WIDTH-1:0] modeOpCode,
   output logic modeLoad,
   output sdram_addr_pkg::wr_beat_t arrayBeat,
   output logic arrayBeatValid,
   input wire logic arrayReady,
   output logic writeStall,
   output logic [15:0] dqOut,
   output logic [15:0] dqOutEnableN
);
   import sdram_addr_pkg::*;

   localparam int LAT = `MASK_LATENCY;
   localparam logic [1:0] ORG_X4 = `ORG_X4;
   localparam logic [1:0] ORG_X8 = `ORG_X8;
   localparam logic [1:0] ORG_X16 = `ORG_X16;

   // Registered copies of the controller inputs, all on the rising edge
   cmd_t cmd;
   logic selN, lowMask, highMask, rdBeat, wrBeat;
   logic [1:0] bank;
   logic [`ADDR_WIDTH-1:0] addr;
   logic [15:0] wData, rData;

   row_sel_t next_rowSelect;
   col_sel_t next_columnSelect;
   logic next_rowValid, next_columnValid, next_modeLoad;
   logic [`BANK_COUNT-1:0] next_prechargeBanks;
   logic [`ADDR_WIDTH-1:0] next_modeOpCode;
   logic [1:0] laneMask;
   logic [LAT-1:0] next_floatLow, next_floatHigh, floatLow, floatHigh;
   logic [15:0] next_dqOut, next_dqOutEnableN;
   logic [9:0] colBits;
   logic accept;
   logic fifoReady;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd <= CMD_NONE;
         selN <= 1'b1;
         bank <= '0;
         addr <= '0;
         lowMask <= 1'b0;
         highMask <= 1'b0;
         rdBeat <= 1'b0;
         wrBeat <= 1'b0;
         wData <= '0;
         rData <= '0;
      end else begin
         cmd <= command;
         selN <= chipSelectN;
         bank <= bankSelect;
         addr <= address;
         lowMask <= low_byte_mask;
         highMask <= high_byte_mask;
         rdBeat <= burstReadBeat;
         wrBeat <= burstWriteBeat;
         wData <= writeData;
         rData <= readData;
      end
   end

   // Narrow parts use the high mask for every data bit
   always_comb begin
      if (organization == ORG_X16) begin
         laneMask = {highMask, lowMask};
      end else begin
         laneMask = {highMask, highMask};
      end
   end

   always_comb begin
      accept = !selN;
      colBits = '0;
      if (organization == ORG_X4) begin
         colBits[`COL_MSB_X4:0] = addr[`COL_MSB_X4:0];
      end else if (organization == ORG_X8) begin
         colBits[`COL_MSB_X8:0] = addr[`COL_MSB_X8:0];
      end else begin
         colBits[`COL_MSB_X16:0] = addr[`COL_MSB_X16:0];
      end
      next_rowSelect = rowSelect;
      next_columnSelect = columnSelect;
      next_modeOpCode = modeOpCode;
      next_rowValid = 1'b0;
      next_columnValid = 1'b0;
      next_modeLoad = 1'b0;
      next_prechargeBanks = '0;
      if (accept) begin
         case (cmd)
            CMD_ACTIVATE: begin
               next_rowSelect.bank = bank;
               next_rowSelect.row = addr;
               next_rowValid = 1'b1;
            end
            CMD_READ, CMD_WRITE: begin
               next_columnSelect.write = (cmd == CMD_WRITE);
               next_columnSelect.autoPrecharge = addr[`SCOPE_BIT];
               next_columnSelect.bank = bank;
               next_columnSelect.column = colBits;
               next_columnValid = 1'b1;
            end
            CMD_PRECHARGE: begin
               if (addr[`SCOPE_BIT]) begin
                  next_prechargeBanks = '1;
               end else begin
                  next_prechargeBanks = `BANK_COUNT'(1) << bank;
               end
            end
            CMD_MODE: begin
               next_modeOpCode = addr;
               next_modeLoad = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // Read masks shift down a pipe so drivers float two edges after sampling
   always_comb begin
      next_floatLow = {floatLow[LAT-2:0], laneMask[0]};
      next_floatHigh = {floatHigh[LAT-2:0], laneMask[1]};
      next_dqOut = rData;
      for (int i = 0; i < 16; i++) begin
         if (i < 8) begin
            next_dqOutEnableN[i] = !(rdBeat && !next_floatLow[LAT-1]);
         end else begin
            next_dqOutEnableN[i] = !(rdBeat && !next_floatHigh[LAT-1]);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rowSelect <= '0;
         columnSelect <= '0;
         rowValid <= 1'b0;
         columnValid <= 1'b0;
         prechargeBanks <= '0;
         modeOpCode <= '0;
         modeLoad <= 1'b0;
         floatLow <= '0;
         floatHigh <= '0;
         dqOut <= '0;
         dqOutEnableN <= 16'hFFFF;
      end else begin
         rowSelect <= next_rowSelect;
         columnSelect <= next_columnSelect;
         rowValid <= next_rowValid;
         columnValid <= next_columnValid;
         prechargeBanks <= next_prechargeBanks;
         modeOpCode <= next_modeOpCode;
         modeLoad <= next_modeLoad;
         floatLow <= next_floatLow;
         floatHigh <= next_floatHigh;
         dqOut <= next_dqOut;
         dqOutEnableN <= next_dqOutEnableN;
      end
   end

   // Write beats carry lane enables; a masked lane is never written
   wr_beat_t fifoIn;
   assign fifoIn.data = wData;
   assign fifoIn.laneEnable = ~laneMask;
   assign writeStall = !fifoReady;

   beat_fifo #(
      .WIDTH($bits(wr_beat_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .inValid(wrBeat),
      .inReady(fifoReady),
      .inData(fifoIn),
      .outValid(arrayBeatValid),
      .outReady(arrayReady),
      .outData(arrayBeat)
   );
endmodule
`default_nettype wire

/* testbench/ctrl_model.sv */
// Controller model driving command, bank, address and byte masks
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
   input wire logic sys_clk,
   output var logic chipSelectN,
   output var sdram_addr_pkg::cmd_t command,
   output var logic [1:0] bankSelect,
   output var logic [11:0] address,
   output var logic low_byte_mask,
   output var logic high_byte_mask
);
   import sdram_addr_pkg::*;
   initial begin
      chipSelectN = 1'b1;
      command = CMD_NONE;
      bankSelect = 2'h0;
      address = 12'h000;
      {low_byte_mask, high_byte_mask} = 2'h0;
   end
   // Called at a falling edge; the command lasts one rising edge
   task automatic issue(input logic cs, input cmd_t c, input logic [1:0] b,
         input logic [11:0] a, input logic lm, input logic hm);
      chipSelectN = cs;
      command = c;
      bankSelect = b;
      address = a;
      low_byte_mask = lm;
      high_byte_mask = hm;
      @(negedge sys_clk);
      command = CMD_NONE;
      address = ~a;
   endtask
   // Changes only the byte masks and holds them for one rising edge
   task automatic set_masks(input logic lm, input logic hm);
      low_byte_mask = lm;
      high_byte_mask = hm;
      @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

/* testbench/sdram_decode_assertions.sv */
// Port checks for the address, bank and mask decode block
`timescale 1ns/1ns
`default_nettype none
module sdram_decode_assertions (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [1:0] organization,
   input wire logic chipSelectN,
   input wire sdram_addr_pkg::cmd_t command,
   input wire logic [1:0] bankSelect,
   input wire logic [11:0] address,
   input wire logic high_byte_mask,
   input wire sdram_addr_pkg::row_sel_t rowSelect,
   input wire logic rowValid,
   input wire sdram_addr_pkg::col_sel_t columnSelect,
   input wire logic columnValid,
   input wire logic [3:0] prechargeBanks,
   input wire logic [11:0] modeOpCode,
   input wire logic modeLoad,
   input wire logic writeStall,
   input wire logic [15:0] dqOutEnableN
);
   import sdram_addr_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic sel;
   assign sel = !chipSelectN;
   property p_row;
      sel && command == CMD_ACTIVATE |-> ##2 rowValid
         && rowSelect == {$past(bankSelect, 2), $past(address, 2)};
   endproperty
   a_row: assert property (p_row) else $error("row select wrong");
   property p_col;
      sel && command == CMD_READ |-> ##2 columnValid && !columnSelect.write
         && columnSelect.autoPrecharge == $past(address[10], 2);
   endproperty
   a_col: assert property (p_col) else $error("read column wrong");
   property p_col16;
      sel && command == CMD_WRITE && organization == 2'h2 |-> ##2 columnSelect.write
         && columnSelect.column == {2'h0, $past(address[7:0], 2)};
   endproperty
   a_col16: assert property (p_col16) else $error("write column wrong");
   property p_pall;
      sel && command == CMD_PRECHARGE && address[10] |-> ##2 prechargeBanks == 4'hF;
   endproperty
   a_pall: assert property (p_pall) else $error("precharge all wrong");
   property p_pone;
      sel && command == CMD_PRECHARGE && !address[10]
         |-> ##2 prechargeBanks == 4'h1 << $past(bankSelect, 2);
   endproperty
   a_pone: assert property (p_pone) else $error("precharge one wrong");
   property p_mode;
      sel && command == CMD_MODE |-> ##2 modeLoad && modeOpCode == $past(address, 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode load wrong");
   property p_ign;
      chipSelectN |-> ##2 !rowValid && !columnValid && !modeLoad && prechargeBanks == 4'h0;
   endproperty
   a_ign: assert property (p_ign) else $error("deselected command acted");
   property p_float;
      high_byte_mask |-> ##3 dqOutEnableN[15:8] == 8'hFF;
   endproperty
   a_float: assert property (p_float) else $error("masked lane driven");
   cover property (rowValid);
   cover property (columnValid && columnSelect.autoPrecharge);
   cover property (writeStall);
endmodule
bind sdram_address_mask_decode sdram_decode_assertions chk_u (.sys_clk, .reset,
   .organization, .chipSelectN, .command, .bankSelect, .address, .high_byte_mask,
   .rowSelect, .rowValid, .columnSelect, .columnValid, .prechargeBanks, .modeOpCode,
   .modeLoad, .writeStall, .dqOutEnableN);
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the address, bank and mask decode block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import sdram_addr_pkg::*;
   logic sys_clk, reset, chipSelectN, low_byte_mask, high_byte_mask, burstReadBeat;
   logic burstWriteBeat, arrayReady, rowValid, columnValid, modeLoad, arrayBeatValid;
   logic writeStall;
   logic [1:0] organization, bankSelect;
   logic [11:0] address, modeOpCode;
   logic [15:0] writeData, dqOutEnableN, readData, dqOut;
   logic [3:0] prechargeBanks;
   cmd_t command;
   row_sel_t rowSelect;
   col_sel_t columnSelect;
   wr_beat_t arrayBeat;
   int bad_count = 0;
   int checked = 0;
   sdram_address_mask_decode dut_u (.sys_clk, .reset, .organization, .chipSelectN,
      .command, .bankSelect, .address, .low_byte_mask, .high_byte_mask, .burstReadBeat,
      .burstWriteBeat, .writeData, .readData, .rowSelect, .rowValid,
      .columnSelect, .columnValid, .prechargeBanks, .modeOpCode, .modeLoad, .arrayBeat,
      .arrayBeatValid, .arrayReady, .writeStall, .dqOut, .dqOutEnableN);
   ctrl_model cm_u (.sys_clk, .chipSelectN, .command, .bankSelect, .address,
      .low_byte_mask, .high_byte_mask);
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic op(input logic cs, input cmd_t c, input logic [1:0] b,
         input logic [11:0] a, input logic lm, input logic hm);
      cm_u.issue(cs, c, b, a, lm, hm);
      @(negedge sys_clk);
   endtask
   task automatic finish_test;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // About 50 cycles of tests; allow 2000
   initial begin
      #40000;
      bad_count++;
      finish_test();
   end
   initial begin
      reset = 1'b1;
      organization = 2'h2;
      burstReadBeat = 1'b0;
      burstWriteBeat = 1'b0;
      writeData = 16'h0000;
      readData = 16'hA55A;
      arrayReady = 1'b0;
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      op(1'b0, CMD_ACTIVATE, 2'h2, 12'hABC, 1'b0, 1'b0);
      chk("rowSelect", {1'b1, 2'h2, 12'hABC}, {rowValid, rowSelect});
      op(1'b1, CMD_MODE, 2'h0, 12'h123, 1'b0, 1'b0);
      chk("ignoredMode", 0, {modeLoad, modeOpCode});
      op(1'b0, CMD_MODE, 2'h0, 12'h237, 1'b0, 1'b0);
      chk("modeOpCode", {1'b1, 12'h237}, {modeLoad, modeOpCode});
      for (int b = 0; b < 4; b++) begin
         op(1'b0, CMD_PRECHARGE, 2'(b), 12'hBFF, 1'b0, 1'b0);
         chk("prechargeOne", 4'h1 << b, prechargeBanks);
      end
      op(1'b0, CMD_PRECHARGE, 2'h1, 12'h400, 1'b0, 1'b0);
      chk("prechargeAll", 4'hF, prechargeBanks);
      op(1'b0, CMD_READ, 2'h3, 12'h5FF, 1'b0, 1'b0);
      chk("columnSelect", {1'b1, 1'b0, 1'b1, 2'h3, 10'h0FF}, {columnValid, columnSelect});
      burstReadBeat = 1'b1;
      op(1'b1, CMD_READ, 2'h0, 12'h000, 1'b1, 1'b0);
      @(negedge sys_clk);
      chk("readFloatLow", {1'b0, 16'h00FF}, {columnValid, dqOutEnableN});
      op(1'b0, CMD_NONE, 2'h0, 12'h000, 1'b0, 1'b1);
      @(negedge sys_clk);
      chk("readFloatHigh", 16'hFF00, dqOutEnableN);
      burstReadBeat = 1'b0;
      burstWriteBeat = 1'b1;
      for (int i = 0; i < 5; i++) begin
         writeData = 16'(16'h1111 * i);
         if (i == 0) begin
            cm_u.issue(1'b0, CMD_WRITE, 2'h1, 12'h4FF, 1'b1, 1'b0);
         end else begin
            cm_u.set_masks(1'b0, i == 1);
         end
      end
      burstWriteBeat = 1'b0;
      @(negedge sys_clk);
      chk("writeStall", 1, writeStall);
      arrayReady = 1'b1;
      for (int i = 0; i < 4; i++) begin
         chk("arrayBeat", {1'b1, 16'(16'h1111 * i), ~(i == 1), ~(i == 0)}, {arrayBeatValid, arrayBeat});
         @(negedge sys_clk);
      end
      chk("arrayBeatValid", 0, arrayBeatValid);
      // Narrow parts: wider column, high mask governs every lane
      organization = 2'h1;
      op(1'b0, CMD_READ, 2'h0, 12'hBFF, 1'b0, 1'b0);
      chk("columnX8", {1'b1, 1'b0, 1'b0, 2'h0, 10'h1FF}, {columnValid, columnSelect});
      burstReadBeat = 1'b1;
      readData = 16'h5AA5;
      op(1'b0, CMD_NONE, 2'h0, 12'h000, 1'b1, 1'b0);
      @(negedge sys_clk);
      chk("narrowLowMask", 16'h0000, dqOutEnableN);
      chk("dqOut", 16'h5AA5, dqOut);
      op(1'b0, CMD_NONE, 2'h0, 12'h000, 1'b0, 1'b1);
      @(negedge sys_clk);
      chk("narrowHighMask", 16'hFFFF, dqOutEnableN);
      burstReadBeat = 1'b0;
      organization = 2'h0;
      op(1'b0, CMD_WRITE, 2'h2, 12'hBFF, 1'b0, 1'b0);
      chk("columnX4", {1'b1, 1'b1, 1'b0, 2'h2, 10'h3FF}, {columnValid, columnSelect});
      finish_test();
   end
endmodule
`default_nettype wire
